// ===== src/chss_pkg.sv
// Package with register offsets, field positions and reset values for channel sync
package chss_pkg;
  localparam int NUM_CH = 6;
  localparam int NUM_PINS = 4;
  localparam int CNT_W = 16;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  // Register byte addresses in the global map
  localparam logic [7:0] ADDR_SOFT_SYNC = 8'h03;
  localparam logic [7:0] ADDR_PIN_SYNC = 8'h04;
  localparam logic [7:0] ADDR_SLEEP = 8'h02;
  // Per-channel register blocks: base plus channel times stride
  localparam logic [7:0] ADDR_CH_BASE = 8'h10;
  localparam logic [7:0] ADDR_CH_STRIDE = 8'h08;
  localparam logic [2:0] CH_START_LO = 3'h0;
  localparam logic [2:0] CH_START_HI = 3'h1;
  localparam logic [2:0] CH_HOP_LO = 3'h2;
  localparam logic [2:0] CH_HOP_HI = 3'h3;
  localparam logic [2:0] CH_NCO_CTRL = 3'h4;
  localparam logic [2:0] CH_STATUS = 3'h5;
  // Soft sync configuration fields
  localparam int SOFT_HOP_BIT = 7;
  localparam int SOFT_START_BIT = 6;
  // Pin sync configuration fields
  localparam int PIN_EDGE_BIT = 7;
  localparam int PIN_HOP_BIT = 6;
  localparam int PIN_START_BIT = 5;
  localparam int PIN_EN_LSB = 0;
  // NCO control field: selected pin
  localparam int NCO_PIN_LSB = 0;
  // Reset values and the hold-off fire count
  localparam logic [7:0] RST_SOFT_SYNC = 8'h00;
  localparam logic [7:0] RST_PIN_SYNC = 8'h00;
  localparam logic [7:0] RST_SLEEP = 8'h00;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [15:0] COUNT_FIRE = 16'h0001;
  localparam logic [1:0] RST_PIN_SEL = 2'h0;
  localparam logic [3:0] RST_PIN_HIST = 4'hF;
  localparam logic [7:0] RST_RD_DATA = 8'h00;
  localparam logic [5:0] RST_CH_FLAGS = 6'h00;
endpackage : chss_pkg

// ===== src/chss_pin_detect.sv
// Sync pin event detector with edge or level sensitivity
`timescale 1ns/10ps
module chss_pin_detect (
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [3:0] sync_pin,
  input wire logic edge_mode,
  output logic [3:0] pin_event
);
  logic [3:0] prev_pin;
  logic [3:0] next_prev_pin;

  always_comb begin
    next_prev_pin = sync_pin;
    if (edge_mode) begin
      pin_event = sync_pin & ~prev_pin; // RULE4
    end else begin
      pin_event = sync_pin; // RULE15
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      prev_pin <= chss_pkg::RST_PIN_HIST;
    end else if (clk_en) begin
      prev_pin <= next_prev_pin;
    end
  end
endmodule : chss_pin_detect

// ===== src/chss_holdoff.sv
// One hold-off down counter that fires its action at count one
`timescale 1ns/10ps
module chss_holdoff (
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [15:0] load_value,
  input wire logic trigger,
  output logic fire,
  output logic busy
);
  logic [15:0] count;
  logic [15:0] next_count;
  logic running;
  logic next_running;

  always_comb begin
    next_count = count;
    next_running = running;
    fire = 1'b0;
    if (trigger) begin
      next_count = load_value;
      next_running = (load_value != chss_pkg::RST_COUNT);
    end else if (running) begin
      if (count == chss_pkg::COUNT_FIRE) begin
        fire = 1'b1; // RULE9
        next_running = 1'b0; // RULE16
      end else begin
        next_count = count - 16'h0001; // RULE16
      end
    end
    busy = running;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      count <= chss_pkg::RST_COUNT;
      running <= 1'b0;
    end else if (clk_en) begin
      count <= next_count;
      running <= next_running;
    end
  end
endmodule : chss_holdoff

// ===== src/chss_sync_top.sv
// Start and hop synchronization control for all channels
`timescale 1ns/10ps
// Contract
// RULE1: Provide start sync and hop sync
// RULE2: Register writes trigger either sync type
// RULE3: Four sync pins, one chosen per channel
// RULE4: Config at 0x04 selects edge/level; rising edge
// RULE5: Reset puts every channel to sleep
// RULE6: Writing zero to sleep bit sleeps channel; a start firing in that same cycle leaves it active
// RULE7: Host enables channels, loads start count first
// RULE8: Host clears soft sync register before enabling
// RULE9: Soft start counts down, activates at one
// RULE10: Serial host writes final soft enable twice
// RULE11: Pin start counts down after pin event
// RULE12: Host writes new words, loads hop count
// RULE13: Soft hop counts down, loads NCO at one
// RULE14: Pin hop counts down, loads NCO at one
// RULE15: Level mode: high pin is sync event
// RULE16: Counters decrement per clock, stop after action
module chss_sync_top (
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  input wire logic [3:0] sync_pin,
  output logic [5:0] ch_active,
  output logic [5:0] ch_start_pulse,
  output logic [5:0] ch_hop_pulse
);
  localparam int N = chss_pkg::NUM_CH;

  logic [7:0] soft_cfg, next_soft_cfg;
  logic [7:0] pin_cfg, next_pin_cfg;
  logic [5:0] sleep_ctl, next_sleep_ctl;
  logic [15:0] start_hold [N];
  logic [15:0] next_start_hold [N];
  logic [15:0] hop_hold [N];
  logic [15:0] next_hop_hold [N];
  logic [1:0] pin_sel [N];
  logic [1:0] next_pin_sel [N];
  logic [7:0] next_rd_data;
  logic [5:0] next_active, next_start_pulse, next_hop_pulse;
  logic [5:0] start_trig, hop_trig, start_fire, hop_fire, start_busy, hop_busy;
  logic [3:0] pin_event;
  logic soft_wr;

  chss_pin_detect u_detect (
    .clock(clock),
    .rst(rst),
    .clk_en(clk_en),
    .sync_pin(sync_pin),
    .edge_mode(pin_cfg[chss_pkg::PIN_EDGE_BIT]),
    .pin_event(pin_event)
  );

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_ch
      chss_holdoff u_start (
        .clock(clock),
        .rst(rst),
        .clk_en(clk_en),
        .load_value(start_hold[g]),
        .trigger(start_trig[g]),
        .fire(start_fire[g]),
        .busy(start_busy[g])
      );
      chss_holdoff u_hop (
        .clock(clock),
        .rst(rst),
        .clk_en(clk_en),
        .load_value(hop_hold[g]),
        .trigger(hop_trig[g]),
        .fire(hop_fire[g]),
        .busy(hop_busy[g])
      );
    end
  endgenerate

  // Register writes, triggers and readback
  always_comb begin
    logic [7:0] off;
    logic [2:0] sub;
    logic pin_ok;
    off = 8'h00;
    sub = 3'h0;
    pin_ok = 1'b0;
    next_soft_cfg = soft_cfg;
    next_pin_cfg = pin_cfg;
    next_sleep_ctl = sleep_ctl;
    next_rd_data = 8'h00;
    soft_wr = wr_en && (addr == chss_pkg::ADDR_SOFT_SYNC);
    for (int c = 0; c < N; c++) begin
      next_start_hold[c] = start_hold[c];
      next_hop_hold[c] = hop_hold[c];
      next_pin_sel[c] = pin_sel[c];
    end
    if (wr_en) begin
      if (addr == chss_pkg::ADDR_SOFT_SYNC) begin
        next_soft_cfg = wr_data; // RULE2
      end
      if (addr == chss_pkg::ADDR_PIN_SYNC) begin
        next_pin_cfg = wr_data; // RULE4
      end
      if (addr == chss_pkg::ADDR_SLEEP) begin
        next_sleep_ctl = wr_data[5:0]; // RULE6
      end
    end
    if (rd_en) begin
      if (addr == chss_pkg::ADDR_SOFT_SYNC) begin
        next_rd_data = soft_cfg;
      end
      if (addr == chss_pkg::ADDR_PIN_SYNC) begin
        next_rd_data = pin_cfg;
      end
      if (addr == chss_pkg::ADDR_SLEEP) begin
        next_rd_data = {2'h0, sleep_ctl};
      end
    end
    for (int c = 0; c < N; c++) begin
      off = 8'(chss_pkg::ADDR_CH_BASE + 8'(c) * chss_pkg::ADDR_CH_STRIDE);
      sub = addr[2:0];
      if (addr[7:3] == off[7:3]) begin
        if (wr_en) begin
          case (sub)
            chss_pkg::CH_START_LO: next_start_hold[c][7:0] = wr_data;
            chss_pkg::CH_START_HI: next_start_hold[c][15:8] = wr_data;
            chss_pkg::CH_HOP_LO: next_hop_hold[c][7:0] = wr_data;
            chss_pkg::CH_HOP_HI: next_hop_hold[c][15:8] = wr_data;
            chss_pkg::CH_NCO_CTRL: next_pin_sel[c] = wr_data[1:0]; // RULE3
            default: begin
            end
          endcase
        end
        if (rd_en) begin
          case (sub)
            chss_pkg::CH_START_LO: next_rd_data = start_hold[c][7:0];
            chss_pkg::CH_START_HI: next_rd_data = start_hold[c][15:8];
            chss_pkg::CH_HOP_LO: next_rd_data = hop_hold[c][7:0];
            chss_pkg::CH_HOP_HI: next_rd_data = hop_hold[c][15:8];
            chss_pkg::CH_NCO_CTRL: next_rd_data = {6'h00, pin_sel[c]};
            chss_pkg::CH_STATUS: begin
              next_rd_data = {5'h00, hop_busy[c], start_busy[c], ch_active[c]};
            end
            default: next_rd_data = 8'h00;
          endcase
        end
      end
    end
    // Sync triggers per channel
    for (int c = 0; c < N; c++) begin
      pin_ok = pin_cfg[chss_pkg::PIN_EN_LSB + 32'(pin_sel[c])] && pin_event[pin_sel[c]]; // RULE3
      start_trig[c] = (soft_wr && wr_data[chss_pkg::SOFT_START_BIT] && wr_data[c]) // RULE9
        || (pin_cfg[chss_pkg::PIN_START_BIT] && pin_ok && !start_busy[c]); // RULE11
      hop_trig[c] = (soft_wr && wr_data[chss_pkg::SOFT_HOP_BIT] && wr_data[c]) // RULE13
        || (pin_cfg[chss_pkg::PIN_HOP_BIT] && pin_ok && !hop_busy[c]); // RULE14
    end
  end

  // Channel activation and NCO load strobes
  always_comb begin
    next_active = ch_active;
    for (int c = 0; c < N; c++) begin
      if (wr_en && addr == chss_pkg::ADDR_SLEEP && !wr_data[c]) begin
        next_active[c] = 1'b0; // RULE6
      end
      if (start_fire[c] && sleep_ctl[c]) begin
        next_active[c] = 1'b1; // RULE1
      end
    end
    next_start_pulse = start_fire; // RULE1
    next_hop_pulse = hop_fire; // RULE13
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      soft_cfg <= chss_pkg::RST_SOFT_SYNC;
      pin_cfg <= chss_pkg::RST_PIN_SYNC;
      sleep_ctl <= chss_pkg::RST_SLEEP[5:0];
      rd_data <= chss_pkg::RST_RD_DATA;
      ch_active <= chss_pkg::RST_CH_FLAGS; // RULE5
      ch_start_pulse <= chss_pkg::RST_CH_FLAGS;
      ch_hop_pulse <= chss_pkg::RST_CH_FLAGS;
      for (int c = 0; c < N; c++) begin
        start_hold[c] <= chss_pkg::RST_COUNT;
        hop_hold[c] <= chss_pkg::RST_COUNT;
        pin_sel[c] <= chss_pkg::RST_PIN_SEL;
      end
    end else if (clk_en) begin
      soft_cfg <= next_soft_cfg;
      pin_cfg <= next_pin_cfg;
      sleep_ctl <= next_sleep_ctl;
      rd_data <= next_rd_data;
      ch_active <= next_active;
      ch_start_pulse <= next_start_pulse;
      ch_hop_pulse <= next_hop_pulse;
      for (int c = 0; c < N; c++) begin
        start_hold[c] <= next_start_hold[c];
        hop_hold[c] <= next_hop_hold[c];
        pin_sel[c] <= next_pin_sel[c];
      end
    end
  end
endmodule : chss_sync_top

// ===== tb/chss_sync_checker.sv
// Checker for channel start and hop sync control
`timescale 1ns/10ps
module chss_sync_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_data,
  input wire logic [3:0] sync_pin,
  input wire logic [5:0] ch_active,
  input wire logic [5:0] ch_start_pulse,
  input wire logic [5:0] ch_hop_pulse
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  wire logic rq = clk_en && rd_en && !wr_en;
  chk_reset_all_sleep: assert property (disable iff (1'b0)
    rst |=> !(|{ch_active, ch_start_pulse, ch_hop_pulse})) else $error("not cleared by reset");
  chk_sleep_write_only: assert property ($fell(ch_active[0])
    |-> $past(wr_en && clk_en && addr == 8'h02 && !wr_data[0])) else $error("slept unasked");
  chk_unmapped_zero: assert property (rq && addr == 8'hFF |=> rd_data == 8'h00)
    else $error("unmapped read not zero");
  chk_cfg_readback: assert property (clk_en && wr_en && addr == 8'h04 ##1
    rq && addr == 8'h04 |=> rd_data == $past(wr_data, 2)) else $error("pin cfg readback");
  chk_wake_on_start: assert property ($rose(ch_active[0]) |-> ch_start_pulse[0])
    else $error("woke without start");
  chk_freeze_hold: assert property (!clk_en |=> $stable({ch_active, ch_start_pulse,
    ch_hop_pulse, rd_data})) else $error("state moved while frozen");
  chk_status_active: assert property (rq && addr == 8'h15
    |=> rd_data[0] == $past(ch_active[0])) else $error("status active bit");
  chk_soft_start_fires: assert property (clk_en && wr_en && addr == 8'h03
    && wr_data[6] && wr_data[0] |-> ##[1:300] ch_start_pulse[0]) else $error("no start");
  cov_start: cover property (ch_start_pulse[0]);
  cov_hop: cover property (ch_hop_pulse[0]);
  cov_sleep: cover property ($fell(ch_active[0]));
endmodule : chss_sync_checker

// ===== tb/chss_sync_source.sv
// Model of the external sync pulse sources
`timescale 1ns/10ps
module chss_sync_source (
  input wire logic clock,
  input wire logic go,
  input wire logic [1:0] pin,
  input wire logic [7:0] len,
  output logic [3:0] sync_pin
);
  logic [7:0] left;
  logic [1:0] sel;
  initial begin
    left = 8'h00;
    sel = 2'h0;
  end
  always @(posedge clock) begin
    if (go) begin
      left <= len;
      sel <= pin;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end
  end
  assign sync_pin = (left != 8'h00) ? (4'h1 << sel) : 4'h0;
endmodule : chss_sync_source

// ===== tb/test_channel_start_hop_sync.sv
// Testbench for channel start and hop sync
`timescale 1ns/10ps
module test_channel_start_hop_sync;
  logic clock, rst, clk_en, wr_en, rd_en, go;
  logic [7:0] addr, wr_data, rd_data, len, cfg;
  logic [3:0] sync_pin;
  logic [1:0] pin;
  logic [5:0] ch_active, ch_start_pulse, ch_hop_pulse, pv;
  logic [15:0] lv [6];
  int mismatches, cmp_count, n, c, k, f;
  int t [6];
  chss_sync_top dut (.clock(clock), .rst(rst), .clk_en(clk_en), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wr_data(wr_data), .rd_data(rd_data), .sync_pin(sync_pin),
    .ch_active(ch_active), .ch_start_pulse(ch_start_pulse), .ch_hop_pulse(ch_hop_pulse));
  chss_sync_source src (.clock(clock), .go(go), .pin(pin), .len(len), .sync_pin(sync_pin));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic summarize;
    $display("mismatches %0d compares %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      mismatches++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    wr_en = 1'b1;
    addr = a;
    wr_data = d;
    @(negedge clock);
    wr_en = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rd_en = 1'b1;
    addr = a;
    @(negedge clock);
    rd_en = 1'b0;
    chk({8'h00, rd_data}, {8'h00, e});
    @(negedge clock);
  endtask : rd
  initial begin
    rst = 1'b1;
    clk_en = 1'b1;
    {wr_en, rd_en, go, addr, wr_data, pin, len} = '0;
    mismatches = 0;
    cmp_count = 0;
    k = $urandom(18194);
    repeat (5) @(negedge clock);
    rst = 1'b0;
    chk(ch_active, 6'h00);
    rd(8'h04, 8'h00);
    wr(8'h02, 8'h3F);
    for (k = 0; k < 2; k++) begin
      for (c = 0; c < 6; c++) begin
        lv[c] = (k == 0 && c == 0) ? 16'h0001 : 16'($urandom_range(40, 2));
        wr(8'h10 + 8'(8 * c) + 8'(2 * k), lv[c][7:0]);
        wr(8'h11 + 8'(8 * c) + 8'(2 * k), lv[c][15:8]);
        t[c] = 0;
      end
      wr(8'h03, 8'h00);
      wr(8'h03, 8'h3F | (8'h40 << k));
      wr(8'h03, 8'h3F | (8'h40 << k));
      f = $urandom_range(3, 1);
      clk_en = 1'b0;
      repeat (f) @(negedge clock);
      clk_en = 1'b1;
      for (n = 1; n <= 60; n++) begin
        @(negedge clock);
        pv = k ? ch_hop_pulse : ch_start_pulse;
        for (c = 0; c < 6; c++) if (pv[c] === 1'b1 && t[c] == 0) t[c] = n;
      end
      for (c = 0; c < 6; c++) chk(16'(t[c]), lv[c]);
      if (mismatches > 0) summarize();
    end
    chk(ch_active, 6'h3F);
    rd(8'h15, 8'h01);
    pin = 2'($urandom_range(3, 0));
    for (c = 0; c < 6; c++) wr(8'h14 + 8'(8 * c), {6'h00, pin});
    wr(8'h12, 8'h04);
    wr(8'h13, 8'h00);
    for (k = 0; k < 3; k++) begin
      cfg = (k == 1 ? 8'h40 : k == 2 ? 8'hA0 : 8'hC0) | (8'h01 << pin);
      wr(8'h04, cfg);
      rd(8'h04, cfg);
      len = 8'h14;
      go = 1'b1;
      @(negedge clock);
      go = 1'b0;
      n = 0;
      for (f = 0; f < 40; f++) begin
        @(negedge clock);
        pv = (k == 2) ? ch_start_pulse : ch_hop_pulse;
        if (pv[0] === 1'b1) n++;
      end
      chk(16'(n == 1 ? 1 : n > 1 ? 2 : 0), k == 1 ? 16'h0002 : 16'h0001);
    end
    wr(8'h02, 8'h00);
    chk(ch_active, 6'h00);
    rd(8'h15, 8'h00);
    rd(8'hFF, 8'h00);
    wr(8'h03, 8'h7F);
    rst = 1'b1;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    chk({ch_active, ch_start_pulse}, 16'h0000);
    summarize();
  end
endmodule : test_channel_start_hop_sync
bind chss_sync_top chss_sync_checker chk (.clock(clock), .rst(rst), .clk_en(clk_en),
  .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data), .rd_data(rd_data),
  .sync_pin(sync_pin), .ch_active(ch_active), .ch_start_pulse(ch_start_pulse),
  .ch_hop_pulse(ch_hop_pulse));
